// ---- design/twrp_device.sv ----
// Slave end: serial register port, register file, reset and standby control
//
// Notes on behaviour
// R1: Address byte: seven address bits plus direction
// R2: Acknowledge a matching slave address byte
// R3: Pointer byte follows write address, acknowledged
// R4: Registers are two bytes, each acknowledged
// R5: Commit register only after both bytes
// R6: Pointer increments after every full word
// R7: Master ends write with stop or start
// R8: Read: write pointer, repeated start, read
// R9: Read bytes out; master nack ends read
// R10: Idle when both lines high; master frames
// R11: Start is data falling while clock high
// R12: Stop is data rising while clock high
// R13: Data changes only while clock low
// R14: Transmitter releases line in acknowledge slot
// R15: Reset pin restores defaults without clock
// R16: Soft reset bit clears all but kept
// R17: Standby by pin or cleared run bit
// R18: Standby refuses reads, limits writable bits
// R19: Standby freezes position, resumes in place
// R20: Entering standby switches multiplier off
// R21: Serial clock comes only from master
// R22: Open-drain data line, phase picks driver
// R23: Ignore transfers to other slave addresses
`timescale 1ns/100ps
module twrp_device
    import twrp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    twrp_bus_if.device bus,
    input wire logic standby_n,
    output logic run_en,
    output logic pll_power,
    output logic pll_use,
    output logic [15:0] frame_pos
);
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic stby_s1;
        logic stby_s2;
        logic in_stby;
        twrp_dstate_t st;
        twrp_role_t role;
        logic rd;
        logic half;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] hold;
        logic [7:0] ptr;
        logic sda_oe;
        logic run;
        logic [15:0] pos;
        logic [NREG-1:0][15:0] regs;
    } twrp_dev_t;

    twrp_dev_t s;
    twrp_dev_t next_s;

    // Byte of the word at the pointer; unmapped words read zero
    function automatic logic [7:0] read_byte(input logic [NREG-1:0][15:0] r,
                                              input logic [7:0] p, input logic lo);
        logic [15:0] w;
        w = (p < NREG_B) ? r[p[4:0]] : 16'h0000;
        read_byte = lo ? w[7:0] : w[15:8];
    endfunction

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic standby;
        logic [15:0] wword;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        standby = 1'b0;
        wword = 16'h0000;
        next_s = s;
        // Pins pass two flops before use
        next_s.scl_s1 = bus.scl; // R21
        next_s.scl_s2 = s.scl_s1;
        next_s.scl_p = s.scl_s2;
        next_s.sda_s1 = bus.sda_in;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_p = s.sda_s2;
        next_s.stby_s1 = standby_n;
        next_s.stby_s2 = s.stby_s1;
        scl_rise = s.scl_s2 && !s.scl_p; // R13
        scl_fall = !s.scl_s2 && s.scl_p; // R13
        start_c = s.scl_s2 && s.scl_p && s.sda_p && !s.sda_s2; // R11
        stop_c = s.scl_s2 && s.scl_p && !s.sda_p && s.sda_s2; // R12

        // Standby from pin (polarity selectable) or run bit
        standby = (s.stby_s2 == s.regs[REG_CHIP_CTRL[4:0]][STBY_POL_BIT]) ||
                  !s.regs[REG_CHIP_CTRL[4:0]][CHIP_RUN_BIT]; // R17
        next_s.in_stby = standby;

        if (stop_c) begin
            next_s.st = d_idle; // R10
            next_s.sda_oe = 1'b0;
        end else if (start_c) begin
            next_s.st = d_recv; // R7
            next_s.role = role_addr;
            next_s.bitn = 4'h0;
            next_s.rd = 1'b0;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.st)
                d_recv: begin
                    if (scl_rise && s.bitn < 4'h8) begin
                        next_s.sh = {s.sh[6:0], s.sda_s2};
                        next_s.bitn = s.bitn + 4'h1;
                    end
                    if (scl_fall && s.bitn == 4'h8) begin
                        next_s.bitn = 4'h0;
                        next_s.st = d_ack;
                        next_s.sda_oe = 1'b1; // R4
                        case (s.role)
                            role_addr: begin
                                if (s.sh[7:1] != SLAVE_ADDR ||
                                    (s.sh[0] == DIR_READ && standby)) begin
                                    next_s.st = d_idle; // R23
                                    next_s.sda_oe = 1'b0; // R18
                                end else begin
                                    next_s.rd = (s.sh[0] == DIR_READ); // R1
                                    next_s.role = role_ptr; // R2
                                end
                            end
                            role_ptr: begin
                                next_s.ptr = s.sh; // R3
                                next_s.role = role_hi;
                            end
                            role_hi: begin
                                next_s.hold = s.sh;
                                next_s.role = role_lo;
                            end
                            role_lo: begin
                                wword = {s.hold, s.sh}; // R5
                                if (!standby && s.ptr < NREG_B) begin
                                    next_s.regs[s.ptr[4:0]] = wword;
                                end else if (standby && s.ptr == REG_CHIP_CTRL) begin
                                    next_s.regs[REG_CHIP_CTRL[4:0]] =
                                        (s.regs[REG_CHIP_CTRL[4:0]] & ~STBY_WRITE_MASK) |
                                        (wword & STBY_WRITE_MASK); // R18
                                end
                                next_s.ptr = s.ptr + 8'h01; // R6
                                next_s.role = role_hi;
                            end
                            default: next_s.st = d_idle;
                        endcase
                    end
                end
                d_ack: begin
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0; // R14
                        if (s.rd) begin
                            next_s.st = d_send; // R8
                            next_s.half = 1'b0;
                            next_s.bitn = 4'h0;
                            next_s.sh = read_byte(s.regs, s.ptr, 1'b0);
                            next_s.sda_oe = !next_s.sh[7]; // R22
                        end else begin
                            next_s.st = d_recv;
                        end
                    end
                end
                d_send: begin
                    if (scl_fall) begin
                        if (s.bitn == 4'h7) begin
                            next_s.sda_oe = 1'b0; // R14
                            next_s.st = d_mack;
                            if (s.half) begin
                                next_s.ptr = s.ptr + 8'h01; // R6
                            end
                        end else begin
                            next_s.bitn = s.bitn + 4'h1;
                            next_s.sh = {s.sh[6:0], 1'b0};
                            next_s.sda_oe = !s.sh[6]; // R9
                        end
                    end
                end
                d_mack: begin
                    if (scl_rise && s.sda_s2) begin
                        next_s.st = d_idle; // R9
                    end else if (scl_fall) begin
                        next_s.st = d_send;
                        next_s.half = !s.half;
                        next_s.bitn = 4'h0;
                        next_s.sh = read_byte(s.regs, s.ptr, !s.half);
                        next_s.sda_oe = !next_s.sh[7];
                    end
                end
                default: begin
                    next_s.st = d_idle;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end

        // Soft reset holds every register but the kept fields at default
        if (s.regs[REG_SOFT_RESET[4:0]][SOFT_RST_BIT]) begin
            for (int i = 0; i < NREG; i++) begin
                next_s.regs[i] = (next_s.regs[i] & soft_keep(8'(i))) |
                                 (reg_default(8'(i)) & ~soft_keep(8'(i))); // R16
            end
        end

        // Multiplier drops out on every standby entry
        if (standby && !s.in_stby) begin
            next_s.regs[REG_PLL_CTRL[4:0]][PLL_POWER_BIT] = 1'b0; // R20
            next_s.regs[REG_PLL_CTRL[4:0]][PLL_USE_BIT] = 1'b0; // R20
        end

        // Position freezes in standby and continues afterwards
        next_s.run = !standby && !s.regs[REG_SOFT_RESET[4:0]][SOFT_RST_BIT];
        if (s.run) begin
            next_s.pos = s.pos + 16'h0001; // R19
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0; // R15
            s.regs[REG_CHIP_CTRL[4:0]] <= CHIP_CTRL_RESET; // R15
            // Synchronisers start at idle pin level, no false edge
            s.scl_s1 <= 1'b1;
            s.scl_s2 <= 1'b1;
            s.scl_p <= 1'b1;
            s.sda_s1 <= 1'b1;
            s.sda_s2 <= 1'b1;
            s.sda_p <= 1'b1;
            s.stby_s1 <= 1'b1;
            s.stby_s2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign bus.dev_sda_out = 1'b0;
    assign bus.dev_sda_oe = s.sda_oe; // R22
    assign run_en = s.run;
    assign pll_power = s.regs[REG_PLL_CTRL[4:0]][PLL_POWER_BIT];
    assign pll_use = s.regs[REG_PLL_CTRL[4:0]][PLL_USE_BIT];
    assign frame_pos = s.pos;
endmodule

// ---- inc/twrp_pkg.sv ----
// Shared constants, types and helpers for the two-wire register port
package twrp_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h5D;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam int NREG = 32;
    localparam logic [7:0] NREG_B = 8'h20;
    localparam logic [7:0] REG_CHIP_CTRL = 8'h07;
    localparam logic [7:0] REG_SOFT_RESET = 8'h0D;
    localparam logic [7:0] REG_PLL_CTRL = 8'h10;
    localparam logic [7:0] REG_PLL_MULT = 8'h11;
    localparam logic [7:0] REG_PLL_DIV = 8'h12;
    localparam int SYNC_BIT = 0;
    localparam int CHIP_RUN_BIT = 1;
    localparam int STBY_POL_BIT = 4;
    localparam int SOFT_RST_BIT = 0;
    localparam int PLL_POWER_BIT = 0;
    localparam int PLL_USE_BIT = 1;
    localparam logic [15:0] CHIP_CTRL_RESET = 16'h0002;
    localparam logic [15:0] OTHER_RESET = 16'h0000;
    localparam logic [15:0] CHIP_CTRL_KEEP = 16'h0003;
    localparam logic [15:0] SOFT_RESET_KEEP = 16'h0001;
    localparam logic [15:0] FULL_KEEP = 16'hFFFF;
    localparam logic [15:0] NO_KEEP = 16'h0000;
    localparam logic [15:0] STBY_WRITE_MASK = 16'h0012;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_QUARTER_NS = 2500;
    localparam logic [7:0] SCL_QUARTER_CYC =
        8'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        d_idle = 3'b000, d_recv = 3'b001, d_ack = 3'b011, d_send = 3'b010, d_mack = 3'b110
    } twrp_dstate_t;
    typedef enum logic [2:0] {
        h_idle = 3'b000, h_start = 3'b001, h_bit = 3'b011, h_stop = 3'b010, h_done = 3'b110
    } twrp_hstate_t;
    typedef enum logic [1:0] {
        role_addr = 2'b00, role_ptr = 2'b01, role_hi = 2'b11, role_lo = 2'b10
    } twrp_role_t;

    function automatic logic [15:0] reg_default(input logic [7:0] idx);
        reg_default = (idx == REG_CHIP_CTRL) ? CHIP_CTRL_RESET : OTHER_RESET;
    endfunction

    function automatic logic [15:0] soft_keep(input logic [7:0] idx);
        case (idx)
            REG_CHIP_CTRL: soft_keep = CHIP_CTRL_KEEP;
            REG_SOFT_RESET: soft_keep = SOFT_RESET_KEEP;
            REG_PLL_CTRL, REG_PLL_MULT, REG_PLL_DIV: soft_keep = FULL_KEEP;
            default: soft_keep = NO_KEEP;
        endcase
    endfunction
endpackage

// ---- inc/twrp_bus_if.sv ----
// Two-wire bus between master and slave with open-drain data resolution
`timescale 1ns/100ps
interface twrp_bus_if;
    logic scl;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic sda_in;

    // Pull-up: line is low only while someone drives a low
    assign sda_in = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

    modport host (output scl, output host_sda_out, output host_sda_oe, input sda_in);
    modport device (input scl, output dev_sda_out, output dev_sda_oe, input sda_in);
endinterface

// ---- design/twrp_host.sv ----
// Master end: one-word register write or read over the two-wire bus
`timescale 1ns/100ps
module twrp_host
    import twrp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    twrp_bus_if.host bus,
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_ptr,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_nack
);
    typedef struct packed {
        twrp_hstate_t st;
        logic [1:0] q;
        logic [7:0] div;
        logic [3:0] bitn;
        logic [2:0] bi;
        logic [7:0] sh;
        logic rd;
        logic [7:0] ptr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic nack;
        logic scl;
        logic sda_oe;
        logic sda_s1;
        logic sda_s2;
        logic ready;
        logic rvalid;
    } twrp_host_t;

    twrp_host_t s;
    twrp_host_t next_s;

    // Byte sent in slot bi of the sequence
    function automatic logic [7:0] tx_byte(input logic [2:0] bi, input logic rd,
                                            input logic [7:0] p, input logic [15:0] w);
        case (bi)
            3'd0: tx_byte = {SLAVE_ADDR, DIR_WRITE};
            3'd1: tx_byte = p;
            3'd2: tx_byte = rd ? {SLAVE_ADDR, DIR_READ} : w[15:8];
            3'd3: tx_byte = w[7:0];
            default: tx_byte = 8'hFF;
        endcase
    endfunction

    always_comb begin
        logic tick;
        logic sending;
        logic last_rx;
        tick = 1'b0;
        sending = 1'b0;
        last_rx = 1'b0;
        next_s = s;
        next_s.sda_s1 = bus.sda_in;
        next_s.sda_s2 = s.sda_s1;
        next_s.rvalid = 1'b0;
        tick = (s.div == 8'h00);
        next_s.div = tick ? SCL_QUARTER_CYC - 8'h01 : s.div - 8'h01;
        sending = !(s.rd && s.bi >= 3'd3);
        last_rx = s.rd && s.bi == 3'd4;
        case (s.st)
            h_idle: begin
                next_s.div = SCL_QUARTER_CYC - 8'h01;
                if (cmd_valid && s.ready) begin
                    next_s.st = h_start;
                    next_s.q = 2'd0;
                    next_s.bi = 3'd0;
                    next_s.nack = 1'b0;
                    next_s.rd = cmd_read;
                    next_s.ptr = cmd_ptr;
                    next_s.wdata = cmd_wdata;
                end
            end
            h_start: begin
                if (tick) begin
                    next_s.q = s.q + 2'd1;
                    case (s.q)
                        2'd0: next_s.sda_oe = 1'b0;
                        2'd1: next_s.scl = 1'b1;
                        2'd2: next_s.sda_oe = 1'b1;
                        default: begin
                            next_s.scl = 1'b0;
                            next_s.sh = tx_byte(s.bi, s.rd, s.ptr, s.wdata);
                            next_s.bitn = 4'h0;
                            next_s.st = h_bit;
                        end
                    endcase
                end
            end
            h_bit: begin
                if (tick) begin
                    next_s.q = s.q + 2'd1;
                    case (s.q)
                        2'd0: begin
                            if (s.bitn == 4'h8) begin
                                next_s.sda_oe = !sending && !last_rx;
                            end else begin
                                next_s.sda_oe = sending && !s.sh[7];
                            end
                        end
                        2'd1: next_s.scl = 1'b1;
                        2'd2: begin
                            if (s.bitn == 4'h8 && sending && s.sda_s2) begin
                                next_s.nack = 1'b1;
                            end else if (s.bitn < 4'h8 && !sending) begin
                                next_s.sh = {s.sh[6:0], s.sda_s2};
                            end
                        end
                        default: begin
                            next_s.scl = 1'b0;
                            if (s.bitn < 4'h8) begin
                                next_s.bitn = s.bitn + 4'h1;
                                if (sending) begin
                                    next_s.sh = {s.sh[6:0], 1'b0};
                                end
                            end else begin
                                if (s.bi == 3'd3 && !sending) begin
                                    next_s.rdata[15:8] = s.sh;
                                end
                                if (s.bi == 3'd4) begin
                                    next_s.rdata[7:0] = s.sh;
                                end
                                if (s.nack || s.bi == 3'd4 || (!s.rd && s.bi == 3'd3)) begin
                                    next_s.st = h_stop; // R7
                                end else if (s.rd && s.bi == 3'd1) begin
                                    next_s.st = h_start; // R8
                                    next_s.bi = 3'd2;
                                end else begin
                                    next_s.bi = s.bi + 3'd1;
                                    next_s.bitn = 4'h0;
                                    next_s.sh = tx_byte(s.bi + 3'd1, s.rd, s.ptr, s.wdata);
                                end
                            end
                        end
                    endcase
                end
            end
            h_stop: begin
                if (tick) begin
                    next_s.q = s.q + 2'd1;
                    case (s.q)
                        2'd0: next_s.sda_oe = 1'b1;
                        2'd1: next_s.scl = 1'b1;
                        2'd2: next_s.sda_oe = 1'b0;
                        default: next_s.st = h_done;
                    endcase
                end
            end
            h_done: begin
                next_s.rvalid = 1'b1;
                next_s.st = h_idle;
            end
            default: next_s.st = h_idle;
        endcase
        next_s.ready = (next_s.st == h_idle);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.scl <= 1'b1;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign bus.scl = s.scl;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe = s.sda_oe;
    assign cmd_ready = s.ready;
    assign rsp_valid = s.rvalid;
    assign rsp_rdata = s.rdata;
    assign rsp_nack = s.nack;
endmodule

// ---- test/twrp_bus_assertions.sv ----
// Concurrent checks on the shared two-wire bus signals
`timescale 1ns/100ps
module twrp_bus_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic sda_in
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_dev_data_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data moved while clock high");
    a_dev_drive_low: assert property ($rose(dev_sda_oe) |-> !scl)
        else $error("device took the line while clock high");
    a_start_by_host: assert property (scl && $past(scl) && $fell(sda_in) |-> $rose(host_sda_oe))
        else $error("start not made by host");
    a_stop_by_host: assert property (scl && $past(scl) && $rose(sda_in) |-> $fell(host_sda_oe))
        else $error("stop not made by host");
    a_idle_after_stop: assert property (scl && $rose(sda_in) |-> !dev_sda_oe [*8])
        else $error("device drives after stop");
    a_start_then_clock: assert property (scl && $fell(sda_in) |-> ##[1:300] $fell(scl))
        else $error("no clock after start");
    a_low_phase_span: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_one_driver: assert property (dev_sda_oe && scl |-> !host_sda_oe)
        else $error("transmitter did not release line");
    a_open_drain: assert property (!host_sda_out && !dev_sda_out)
        else $error("data line driven high");
    c_dev_ack: cover property ($rose(dev_sda_oe));
endmodule

// ---- test/testbench.sv ----
// Self-checking bench: host and device joined over the two-wire bus
`timescale 1ns/100ps
module testbench;
    import twrp_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic standby_n = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_ptr = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_ready, rsp_valid, rsp_nack, run_en, pll_power, pll_use;
    logic [15:0] rsp_rdata, frame_pos;
    int n_fail = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    twrp_bus_if bus();
    twrp_host i_twrp_host (.clk(clk), .nrst(nrst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
    twrp_device i_twrp_device (.clk(clk), .nrst(nrst), .bus(bus), .standby_n(standby_n),
        .run_en(run_en), .pll_power(pll_power), .pll_use(pll_use), .frame_pos(frame_pos));
    twrp_bus_checker i_twrp_bus_checker (.clk(clk), .nrst(nrst), .scl(bus.scl),
        .host_sda_out(bus.host_sda_out), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_out(bus.dev_sda_out), .dev_sda_oe(bus.dev_sda_oe), .sda_in(bus.sda_in));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One command through the host, wait for its single-cycle response
    task automatic do_cmd(input logic rd, input logic [7:0] ptr, input logic [15:0] wd);
        int i;
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_ptr = ptr;
        cmd_wdata = wd;
        for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) tick(1);
        tick(1);
        cmd_valid = 1'b0;
        for (i = 0; i < 60000 && rsp_valid !== 1'b1; i++) tick(1);
        chk1(rsp_valid, 1'b1);
    endtask

    task automatic t_reset_state();
        logic [15:0] fp;
        chk1(cmd_ready, 1'b1);
        chk1(bus.sda_in, 1'b1);
        chk1(bus.scl, 1'b1);
        chk1(pll_power, 1'b0);
        chk1(run_en, 1'b1);
        fp = frame_pos;
        tick(10);
        chk16(frame_pos, fp + 16'h000a);
    endtask

    task automatic t_write_word();
        chk1(pll_power, 1'b0);
        do_cmd(1'b0, REG_PLL_CTRL, 16'h0003);
        chk1(rsp_nack, 1'b0);
        chk1(pll_power, 1'b1);
        chk1(pll_use, 1'b1);
    endtask

    task automatic t_standby();
        logic [15:0] frz;
        standby_n = 1'b0;
        tick(8);
        chk1(run_en, 1'b0);
        chk1(pll_power, 1'b0);
        chk1(pll_use, 1'b0);
        frz = frame_pos;
        tick(20);
        chk16(frame_pos, frz);
        standby_n = 1'b1;
        tick(8);
        chk1(run_en, 1'b1);
        chk1(pll_power, 1'b0);
        chk1(frame_pos > frz && frame_pos < frz + 16'h000a, 1'b1);
    endtask

    task automatic t_read_word();
        do_cmd(1'b1, REG_PLL_CTRL, 16'h0000);
        chk1(rsp_nack, 1'b0);
        chk16(rsp_rdata, 16'h0003);
        chk1(cmd_ready, 1'b1);
        tick(4);
        chk1(bus.sda_in, 1'b1);
    endtask

    initial begin
        tick(16);
        nrst = 1'b1;
        tick(6);
        t_reset_state();
        t_write_word();
        t_read_word();
        t_standby();
        finish_test();
    end

    initial begin
        #950000;
        n_fail++;
        finish_test();
    end
endmodule
